// >>> pkg/port_ctrl_pkg.sv
// Constants for the board output port control block: local bus byte
// addresses, output port and pin config bit positions, reset values.
// Assumes byte accesses from the host processors on a 32-bit address bus.
package port_ctrl_pkg;

  // ----------------------------------------------------------------
  // Local bus byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] SECOND_UART_INPUT_PORT = 32'hfe200037;
  localparam logic [31:0] SECOND_UART_OUTPUT_SET = 32'hfe20003b;
  localparam logic [31:0] SECOND_UART_OUTPUT_CLEAR = 32'hfe20003f;
  localparam logic [31:0] FIRST_UART_INPUT_AND_PIN_CONFIG = 32'hfe280037;
  localparam logic [31:0] FIRST_UART_OUTPUT_SET = 32'hfe28003b;
  localparam logic [31:0] FIRST_UART_OUTPUT_CLEAR = 32'hfe28003f;
  localparam logic [31:0] LED_AND_FUNCTION_COMMAND = 32'hfe380003;

  // ----------------------------------------------------------------
  // Output port bit positions
  // ----------------------------------------------------------------
  localparam int FIRST_CHANNEL_RTS_BIT = 0;
  localparam int SECOND_CHANNEL_RTS_BIT = 1;
  localparam int SYSFAIL_GATE_BIT = 2;
  localparam int TIMER_IRQ_PIN_BIT = 3;
  localparam int LINE_DRIVER_ENABLE_BIT = 4;
  localparam int INTERRUPTER_LEVEL_LSB = 5;
  localparam int INTERRUPTER_LEVEL_MSB = 7;

  // Pin function config field: bits 3:2, code 01 puts the timer on pin 3.
  localparam int PIN_CONFIG_LSB = 2;
  localparam int PIN_CONFIG_MSB = 3;
  localparam logic [1:0] PIN_CONFIG_TIMER_ON_PIN3 = 2'h1;
  localparam logic [1:0] PIN_CONFIG_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FIRST_OUTPUT_RESET = 8'he0;
  localparam logic [7:0] SECOND_OUTPUT_RESET = 8'h00;
  localparam logic [7:0] FIRST_OUTPUT_MASK = 8'hff;
  localparam logic [7:0] SECOND_OUTPUT_MASK = 8'h1b;
  localparam logic [3:0] LED_ON_RESET = 4'hf;

  // Command codes: bit 3 set means off, low two bits pick the LED.
  localparam int LED_OFF_BIT = 3;
  localparam int LED_FUNC_BIT = 2;

  // Synchroniser width: cts 4, crystal 2, timer irq 2, serial irq 2, sysfail 1.
  localparam int SYNC_WIDTH = 11;

endpackage : port_ctrl_pkg

// >>> rtl/board_output_port_control.sv
// Board output port control: the two UART general purpose output
// ports, their input ports, pin function config and the LED command.
// Assumes single-cycle byte strobes from the local bus on ref_clk and
// asynchronous board pins that are synchronised here.
`timescale 1ns/1ps
module board_output_port_control
  import port_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [31:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_ack,
  input wire logic [3:0] cts_in,
  input wire logic [1:0] timer_crystal_input,
  input wire logic [1:0] timer_irq_in,
  input wire logic [1:0] serial_irq_in,
  input wire logic sysfail_n_in,
  output logic [3:0] rts_out,
  output logic [3:0] line_driver_en,
  output logic sysfail_rx_en,
  output logic sysfail_seen,
  output logic [2:0] interrupter_level_bits,
  output logic sysres_mode,
  output logic [1:0] irq_level6,
  output logic [1:0] irq_level5,
  output logic [3:0] led_on,
  output logic [3:0] func_code,
  output logic func_pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Set and clear are separate addresses, so one write never does both.
  function automatic logic [7:0] port_update(
    input logic [7:0] old_val,
    input logic [7:0] data,
    input logic do_set,
    input logic do_clr,
    input logic [7:0] mask
  );
    logic [7:0] v;
    v = old_val;
    if (do_set) begin
      v = v | data;
    end
    if (do_clr) begin
      v = v & ~data;
    end
    return v & mask;
  endfunction : port_update

  function automatic logic timer_on_pin3(input logic [1:0] cfg);
    return cfg == PIN_CONFIG_TIMER_ON_PIN3;
  endfunction : timer_on_pin3

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic [3:0] cts_s;
  logic [1:0] xtal_s;
  logic [1:0] timer_s;
  logic [1:0] serial_s;
  logic sysfail_n_s;

  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({sysfail_n_in, serial_irq_in, timer_irq_in,
               timer_crystal_input, cts_in}),
    .sync_out(pins_sync)
  );

  assign cts_s = pins_sync[3:0];
  assign xtal_s = pins_sync[5:4];
  assign timer_s = pins_sync[7:6];
  assign serial_s = pins_sync[9:8];
  assign sysfail_n_s = pins_sync[10];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_set1;
  logic wr_clr1;
  logic wr_set2;
  logic wr_clr2;
  logic wr_cfg1;
  logic wr_cfg2;
  logic wr_mode;

  // Strobes for each write target.
  assign wr_set1 = bus_wr && (bus_addr == FIRST_UART_OUTPUT_SET);
  assign wr_clr1 = bus_wr && (bus_addr == FIRST_UART_OUTPUT_CLEAR);
  assign wr_set2 = bus_wr && (bus_addr == SECOND_UART_OUTPUT_SET);
  assign wr_clr2 = bus_wr && (bus_addr == SECOND_UART_OUTPUT_CLEAR);
  assign wr_cfg1 = bus_wr && (bus_addr == FIRST_UART_INPUT_AND_PIN_CONFIG);
  assign wr_cfg2 = bus_wr && (bus_addr == SECOND_UART_INPUT_PORT);
  assign wr_mode = bus_wr && (bus_addr == LED_AND_FUNCTION_COMMAND);

  // ----------------------------------------------------------------
  // Output port registers
  // ----------------------------------------------------------------
  logic [7:0] out1_reg;
  logic [7:0] out2_reg;
  logic [1:0] cfg1_reg;
  logic [1:0] cfg2_reg;

  // Both ports reset with drivers and RTS off; the first port also with SysFail gate off and level 7.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out1_reg <= FIRST_OUTPUT_RESET;
      out2_reg <= SECOND_OUTPUT_RESET;
    end else begin
      out1_reg <= port_update(out1_reg, bus_wdata, wr_set1, wr_clr1,
                              FIRST_OUTPUT_MASK);
      out2_reg <= port_update(out2_reg, bus_wdata, wr_set2, wr_clr2,
                              SECOND_OUTPUT_MASK);
    end
  end

  // Pin function config; only the field that steers the timer is kept.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg1_reg <= PIN_CONFIG_RESET;
      cfg2_reg <= PIN_CONFIG_RESET;
    end else begin
      if (wr_cfg1) begin
        cfg1_reg <= bus_wdata[PIN_CONFIG_MSB:PIN_CONFIG_LSB];
      end
      if (wr_cfg2) begin
        cfg2_reg <= bus_wdata[PIN_CONFIG_MSB:PIN_CONFIG_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Board outputs taken straight from the port registers and the A/C driver flop
  // ----------------------------------------------------------------

  // RTS of ports A, B come from the first UART, C, D from the second.
  assign rts_out = {out2_reg[SECOND_CHANNEL_RTS_BIT], out2_reg[FIRST_CHANNEL_RTS_BIT],
                    out1_reg[SECOND_CHANNEL_RTS_BIT], out1_reg[FIRST_CHANNEL_RTS_BIT]};
  assign sysfail_rx_en = out1_reg[SYSFAIL_GATE_BIT];
  assign interrupter_level_bits = out1_reg[INTERRUPTER_LEVEL_MSB:INTERRUPTER_LEVEL_LSB];

  logic drv_ac_reg;

  // Ports A and C have no tri-state control; this flop only leaves reset.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drv_ac_reg <= 1'b1;
    end else begin
      drv_ac_reg <= 1'b1;
    end
  end

  // Enables ordered A, B, C, D; zero holds TxD and RTS drivers in high-z.
  assign line_driver_en = {out2_reg[LINE_DRIVER_ENABLE_BIT], drv_ac_reg,
                           out1_reg[LINE_DRIVER_ENABLE_BIT], drv_ac_reg};

  // ----------------------------------------------------------------
  // Interrupt routing, interrupter mode and SysFail reception
  // ----------------------------------------------------------------
  logic t_pin3_1;
  logic t_pin3_2;

  assign t_pin3_1 = timer_on_pin3(cfg1_reg);
  assign t_pin3_2 = timer_on_pin3(cfg2_reg);

  // Registered so every interrupt output leaves a flop; costs one cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_level6 <= 2'h0;
      irq_level5 <= 2'h0;
    end else begin
      irq_level6[0] <= t_pin3_1 && (out1_reg[TIMER_IRQ_PIN_BIT] || timer_s[0]);
      irq_level6[1] <= t_pin3_2 && (out2_reg[TIMER_IRQ_PIN_BIT] || timer_s[1]);
      irq_level5[0] <= serial_s[0] || (!t_pin3_1 && timer_s[0]);
      irq_level5[1] <= serial_s[1] || (!t_pin3_2 && timer_s[1]);
    end
  end

  // Level code zero turns the interrupter into a bus reset source.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sysres_mode <= 1'b0;
    end else begin
      sysres_mode <= (out1_reg[INTERRUPTER_LEVEL_MSB:INTERRUPTER_LEVEL_LSB] == 3'h0);
    end
  end

  // SysFail is only reported while the gate bit allows reception.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sysfail_seen <= 1'b0;
    end else begin
      sysfail_seen <= out1_reg[SYSFAIL_GATE_BIT] && !sysfail_n_s;
    end
  end

  // ----------------------------------------------------------------
  // LED and function command
  // ----------------------------------------------------------------

  // Codes 0-3 and 8-B steer the LEDs; 4-7 and C-F leave as a pulse.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      led_on <= LED_ON_RESET;
      func_code <= 4'h0;
      func_pulse <= 1'b0;
    end else begin
      func_pulse <= 1'b0;
      if (wr_mode && (bus_wdata[7:4] == 4'h0)) begin
        if (!bus_wdata[LED_FUNC_BIT]) begin
          led_on[bus_wdata[1:0]] <= !bus_wdata[LED_OFF_BIT];
        end else begin
          func_code <= bus_wdata[3:0];
          func_pulse <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_next;

  // Only the input ports are readable; all else reads as zero.
  always_comb begin
    rdata_next = 8'h00;
    if (bus_addr == FIRST_UART_INPUT_AND_PIN_CONFIG) begin
      rdata_next = {5'h00, xtal_s[0], cts_s[2], cts_s[0]};
    end else if (bus_addr == SECOND_UART_INPUT_PORT) begin
      rdata_next = {5'h00, xtal_s[1], cts_s[3], cts_s[1]};
    end
  end

  // Every access is answered one cycle later, mapped or not.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
      bus_rdata <= 8'h00;
    end else begin
      bus_ack <= bus_wr || bus_rd;
      if (bus_rd) begin
        bus_rdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence write_seq(logic [31:0] a, logic [7:0] d);
    bus_wr && !bus_rd && (bus_addr == a) && (bus_wdata == d);
  endsequence

  sequence quiet_seq;
    !bus_wr ##1 !bus_wr;
  endsequence

  chk_led_one_off: assert property (
    write_seq(LED_AND_FUNCTION_COMMAND, 8'h09) |=> !led_on[1])
    else $error("LED 1 still on after off command.");

  chk_port_b_on: assert property (
    write_seq(FIRST_UART_OUTPUT_SET, 8'h10) |=> line_driver_en[1])
    else $error("Port B drivers not enabled.");

  chk_port_b_off: assert property (
    write_seq(FIRST_UART_OUTPUT_CLEAR, 8'h10) |=> !line_driver_en[1])
    else $error("Port B drivers not tri-stated.");

  chk_port_d_pair: assert property (
    write_seq(SECOND_UART_OUTPUT_SET, 8'h10) ##1 write_seq(SECOND_UART_OUTPUT_CLEAR, 8'h10)
    |-> line_driver_en[3] ##1 !line_driver_en[3])
    else $error("Port D driver sequence wrong.");

  chk_ac_always: assert property (
    line_driver_en[0] && line_driver_en[2])
    else $error("Ports A or C drivers disabled.");

  chk_irq6_route: assert property (
    t_pin3_1 && out1_reg[TIMER_IRQ_PIN_BIT] |=> irq_level6[0])
    else $error("Level 6 not raised by pin 3 bit.");

  chk_irq5_share: assert property (
    !t_pin3_2 && timer_s[1] |=> irq_level5[1] && !irq_level6[1])
    else $error("Shared timer interrupt not on level 5.");

  chk_sysfail_gate: assert property (
    write_seq(FIRST_UART_OUTPUT_CLEAR, 8'h04) |=> !sysfail_rx_en ##1 !sysfail_seen)
    else $error("SysFail reception not disabled.");

  chk_sysres_code: assert property (
    write_seq(FIRST_UART_OUTPUT_CLEAR, 8'he0) ##1 quiet_seq |-> sysres_mode)
    else $error("Level zero did not select reset.");

  chk_second_unused: assert property (
    (out2_reg & ~SECOND_OUTPUT_MASK) == 8'h00)
    else $error("Unused second port bits set.");

  chk_rts_set_only: assert property (
    write_seq(FIRST_UART_OUTPUT_SET, 8'h01) |=> rts_out[0]
    && ($past(out1_reg) | 8'h01) == out1_reg)
    else $error("Set write disturbed other bits.");

endmodule : board_output_port_control

// >>> rtl/pin_sync.sv
// Two flip-flop synchroniser for a bundle of unrelated level inputs.
// Assumes each bit is an independent slow level; no bus coherence.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second, so a metastable value never
  // reaches any decision logic.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pin_sync

// >>> testbench/board_output_port_control_tb.sv
// Self-checking bench for the board output port control block.
// Assumes host_bus_model and the design package are compiled first.
`timescale 1ns/1ps
module board_output_port_control_tb
  import port_ctrl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic bus_ack;
  logic [3:0] cts_in = 4'h0;
  logic [1:0] timer_crystal_input = 2'h0;
  logic [1:0] timer_irq_in = 2'h0;
  logic [1:0] serial_irq_in = 2'h0;
  logic sysfail_n_in = 1'b1;
  logic [3:0] rts_out;
  logic [3:0] line_driver_en;
  logic sysfail_rx_en;
  logic sysfail_seen;
  logic [2:0] interrupter_level_bits;
  logic sysres_mode;
  logic [1:0] irq_level6;
  logic [1:0] irq_level5;
  logic [3:0] led_on;
  logic [3:0] func_code;
  logic func_pulse;
  logic [7:0] op [2];
  logic [1:0] routed;
  logic [3:0] led;
  logic [3:0] fcode;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'h4e3532be;
  logic [31:0] r;

  board_output_port_control u_dut (.ref_clk(ref_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .cts_in(cts_in), .timer_crystal_input(timer_crystal_input),
    .timer_irq_in(timer_irq_in), .serial_irq_in(serial_irq_in), .sysfail_n_in(sysfail_n_in),
    .rts_out(rts_out), .line_driver_en(line_driver_en), .sysfail_rx_en(sysfail_rx_en),
    .sysfail_seen(sysfail_seen), .interrupter_level_bits(interrupter_level_bits),
    .sysres_mode(sysres_mode), .irq_level6(irq_level6), .irq_level5(irq_level5),
    .led_on(led_on), .func_code(func_code), .func_pulse(func_pulse));

  host_bus_model u_host (.ref_clk(ref_clk), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

  // ----------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------
  // A 5 ns clock.
  always #2.5 ref_clk = ~ref_clk;

  // Every comparison funnels through here so the counts stay honest.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // A hang counts as a failure; the tests need about 2,000 cycles, this allows 40,000.
  initial begin
    #200000;
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Bus helpers and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic ack;
    logic [7:0] q;
    u_host.access(a, d, 1'b0, ack, q);
    check(32'(ack), 32'h1);
  endtask : wr

  // Set and clear touch only the one bits; second port bits 2, 5-7 are dead.
  task automatic port_wr(input int u, input logic clr, input logic [7:0] d);
    logic [7:0] m;
    logic [31:0] a;
    m = u ? SECOND_OUTPUT_MASK : FIRST_OUTPUT_MASK;
    a = u ? (clr ? SECOND_UART_OUTPUT_CLEAR : SECOND_UART_OUTPUT_SET)
          : (clr ? FIRST_UART_OUTPUT_CLEAR : FIRST_UART_OUTPUT_SET);
    wr(a, d);
    op[u] = clr ? (op[u] & ~(d & m)) : (op[u] | (d & m));
  endtask : port_wr

  // Only config code 01 in bits 3:2 puts the timer on its own pin.
  task automatic cfg_wr(input int u, input logic [7:0] d);
    wr(u ? SECOND_UART_INPUT_PORT : FIRST_UART_INPUT_AND_PIN_CONFIG, d);
    routed[u] = (d[3:2] == 2'b01);
  endtask : cfg_wr

  // Waits out the pin synchronisers, then compares every port output.
  task automatic check_ports();
    repeat (4) @(posedge ref_clk);
    #1;
    check(32'(rts_out), {28'h0, op[1][1:0], op[0][1:0]});
    check(32'(line_driver_en), {28'h0, op[1][4], 1'b1, op[0][4], 1'b1});
    check(32'(sysfail_rx_en), 32'(op[0][2]));
    check(32'(sysfail_seen), 32'(op[0][2] & ~sysfail_n_in));
    check(32'(interrupter_level_bits), 32'(op[0][7:5]));
    check(32'(sysres_mode), 32'(op[0][7:5] == 3'h0));
    for (int u = 0; u < 2; u++) begin
      check(32'(irq_level6[u]), 32'(routed[u] & (op[u][3] | timer_irq_in[u])));
      check(32'(irq_level5[u]), 32'(serial_irq_in[u] | (~routed[u] & timer_irq_in[u])));
    end
  endtask : check_ports

  task automatic rd_in(input int u);
    logic ack;
    logic [7:0] q;
    u_host.access(u ? SECOND_UART_INPUT_PORT : FIRST_UART_INPUT_AND_PIN_CONFIG,
                  8'h00, 1'b1, ack, q);
    check(32'(q), {29'h0, timer_crystal_input[u], cts_in[u+2], cts_in[u]});
  endtask : rd_in

  // Commands with a nonzero upper nibble must change nothing.
  task automatic mode_wr(input logic [7:0] d);
    wr(LED_AND_FUNCTION_COMMAND, d);
    if (d[7:4] == 4'h0 && d[2]) fcode = d[3:0];
    else if (d[7:4] == 4'h0) led[d[1:0]] = !d[3];
    check(32'(func_pulse), 32'(d[7:4] == 4'h0 && d[2]));
    check(32'(func_code), 32'(fcode));
    check(32'(led_on), 32'(led));
  endtask : mode_wr

  task automatic do_reset();
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    op[0] = 8'he0;
    op[1] = 8'h00;
    routed = 2'b00;
    led = 4'hf;
    fcode = 4'h0;
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Corner cases first, then a random mix, then a reset and a last check.
  initial begin
    do_reset();
    check_ports();
    for (int k = 0; k < 4; k++) begin
      port_wr(k % 2, k / 2, 8'h10);
      check_ports();
    end
    for (int c = 0; c < 8; c++) begin
      port_wr(0, 1'b1, 8'he0);
      port_wr(0, 1'b0, 8'(c << 5));
      check_ports();
    end
    port_wr(1, 1'b0, 8'he4);
    check_ports();
    for (int u = 0; u < 2; u++) begin
      cfg_wr(u, 8'h04);
      port_wr(u, 1'b0, 8'h08);
      check_ports();
    end
    for (int c = 0; c < 16; c++) mode_wr(8'(c));
    mode_wr(8'h5a);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      u_host.led_pattern(r[3:0], r[4]);
      if (r[4]) led = r[3:0];
      check(32'(led_on), 32'(led));
    end
    for (int n = 0; n < 300; n++) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: port_wr(r[2], r[3], r[15:8]);
        2'd1: cfg_wr(r[2], r[15:8]);
        2'd2: {cts_in, timer_crystal_input, timer_irq_in, serial_irq_in, sysfail_n_in} = r[26:16];
        default: begin
          rd_in(0);
          rd_in(1);
        end
      endcase
      check_ports();
    end
    do_reset();
    check_ports();
    mode_wr(8'h0b);
    close_out();
  end
endmodule : board_output_port_control_tb

// >>> testbench/host_bus_model.sv
// Host processor model: byte reads and writes on the local bus.
// Assumes the bench calls its tasks from a single process only.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata,
  output logic [31:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // The bus idles quietly until the first access.
  initial begin
    bus_addr = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // One access: a one-cycle strobe, answer taken after the taking edge.
  // Strobes drop to zero; address and data are inverted so a stale value can never look valid.
  task automatic access(input logic [31:0] a, input logic [7:0] d, input logic rd,
                        output logic ack, output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = !rd;
    bus_rd = rd;
    @(posedge ref_clk);
    #1;
    ack = bus_ack;
    q = bus_rdata;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask : access

  // Pattern routine: only with the bus-owner bit set do the writes reach the LED command address; one write per LED.
  task automatic led_pattern(input logic [3:0] v, input logic owner);
    logic ack;
    logic [7:0] q;
    logic [31:0] a;
    a = owner ? 32'hfe380003 : 32'hfe384003;
    for (int i = 0; i < 4; i++) begin
      access(a, v[i] ? 8'(i) : (8'(i) | 8'h08), 1'b0, ack, q);
    end
  endtask : led_pattern
endmodule : host_bus_model
